// File: verilog/dasr_params.svh
// Constants of the dual converter readout and power control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DASR_PARAMS_SVH
`define DASR_PARAMS_SVH

// Clock rate of the block clock
`define DASR_CLK_MHZ 250

// Serial clock falling-edge counts that steer the frame
`define DASR_CNT_W 6
`define DASR_CNT_PD_LO 6'h02
`define DASR_CNT_KEEP 6'h0a
`define DASR_CNT_TRACK 6'h0d
`define DASR_CNT_WORD 6'h10
`define DASR_CNT_END 6'h20
`define DASR_CNT_MAX 6'h3f

// Output word layout
`define DASR_RES_W 12
`define DASR_BIT_ZERO 15
`define DASR_BIT_RANGE 14
`define DASR_BIT_CHAN 13
`define DASR_BIT_CONV 12

// Power-up time from full power-down, in ns, and its cycle count
`define DASR_PWRUP_NS 1000
`define DASR_PWRUP_CYC ((`DASR_PWRUP_NS * `DASR_CLK_MHZ + 999) / 1000)
`define DASR_TMR_W 9

// Register byte offsets on APB
`define DASR_ADDR_W 8
`define DASR_OFS_CTRL 8'h00
`define DASR_OFS_STATUS 8'h04
`define DASR_OFS_LASTCNT 8'h08

// Control register fields and reset values
`define DASR_CTRL_RANGE 0
`define DASR_CTRL_CHAN 1
`define DASR_CTRL_RST 2'h0

// Status register fields
`define DASR_ST_MODE_LO 0
`define DASR_ST_MODE_HI 1
`define DASR_ST_FRAME 2
`define DASR_ST_HOLD 3
`define DASR_ST_VALID 4
`define DASR_ST_ANALOG 5
`define DASR_ST_REF 6

`endif

// File: verilog/dasr_pkg.sv
// Types shared by the readout and power control block.
// Assumes the constants header sits beside it.
`include "dasr_params.svh"

package dasr_pkg;

    // Power state of the converter pair
    typedef enum logic [1:0] {
        DASR_NORMAL  = 2'h0,
        DASR_PARTIAL = 2'h1,
        DASR_FULL    = 2'h2,
        DASR_WAKING  = 2'h3
    } dasr_mode_e;

    typedef logic [`DASR_CNT_W-1:0] dasr_cnt_t;
    typedef logic [`DASR_RES_W-1:0] dasr_res_t;

endpackage

// File: verilog/dasr_ctrl.sv
// Serial readout framing and power-mode control of a dual converter.
// Assumes select and serial clock arrive asynchronously from a host,
// results come from converter cores on the block clock, and an APB
// master reaches the control and status registers.
//
// Behaviour
// - Select fall samples, holds, drives outputs
// - One word takes sixteen serial clocks
// - Rise after ten: stay powered, abort
// - Select rise ends frame, tristates outputs
// - Further sixteen clocks give other word
// - Tristate on thirty-second falling edge
// - Normal, rise two-to-ten: partial power-down
// - Normal, rise before two: stay normal
// - Partial exit powers up over frame
// - Partial, rise before two: stay partial
// - Partial, rise two-to-ten: full power-down
// - No remaining clocks needed after rise
// - Full exit: dummy frame, then power-up wait
// - Track again after thirteenth falling edge
// - Select fall gives leading zero first
// - Last bit out on fifteenth fall
// - Bit fourteen shows the input range
// - Bit thirteen shows the input channel
// - Bit twelve shows the converter
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "dasr_params.svh"

module dasr_ctrl
    import dasr_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DASR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host serial pins
    input wire logic conv_start_select_n,
    input wire logic serial_clock,
    output logic serial_out_a,
    output logic serial_out_a_oe,
    output logic serial_out_b,
    output logic serial_out_b_oe,
    // Converter cores
    input wire logic [`DASR_RES_W-1:0] conv_result_a,
    input wire logic [`DASR_RES_W-1:0] conv_result_b,
    output logic hold,
    output logic channel_select_flag,
    output logic range_double,
    output logic analog_power,
    output logic ref_power
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic cs_s1_r, cs_s2_r, cs_s3_r;
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic cs_fall, cs_rise, sck_fall, sck_rise;

    // Both pins idle high; the third stage only feeds edge detection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_s3_r <= 1'b1;
        end else if (ce) begin
            cs_s1_r <= conv_start_select_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            sck_s1_r <= serial_clock;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
        end
    end

    // Serial clock edges only count while select is low
    assign cs_fall = cs_s3_r & ~cs_s2_r;
    assign cs_rise = ~cs_s3_r & cs_s2_r;
    assign sck_fall = sck_s3_r & ~sck_s2_r & ~cs_s2_r & ~cs_fall;
    assign sck_rise = ~sck_s3_r & sck_s2_r & ~cs_s2_r;

    ////////////////////////////////////////////////////////////////////
    // Control register and captured results

    logic range_r, chan_r;
    dasr_res_t res_a_r, res_b_r;

    // Software steers range and channel; a write lands at the access edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            range_r <= 1'(`DASR_CTRL_RST >> `DASR_CTRL_RANGE);
            chan_r <= 1'(`DASR_CTRL_RST >> `DASR_CTRL_CHAN);
        end else if (ce && psel && penable && pready && pwrite &&
                     paddr == `DASR_OFS_CTRL) begin
            range_r <= pwdata[`DASR_CTRL_RANGE];
            chan_r <= pwdata[`DASR_CTRL_CHAN];
        end
    end

    // Results are taken at the sampling instant so the word is stable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            res_a_r <= '0;
            res_b_r <= '0;
        end else if (ce && cs_fall) begin
            res_a_r <= conv_result_a;
            res_b_r <= conv_result_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Falling-edge counter

    dasr_cnt_t cnt_r, cnt_nxt;
    logic frame_r;

    // Cleared at select fall, saturates so idle-low select stays quiet
    always_comb begin
        cnt_nxt = cnt_r;
        if (cs_fall)
            cnt_nxt = '0;
        else if (sck_fall && cnt_r != `DASR_CNT_MAX)
            cnt_nxt = cnt_r + 6'h01;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            cnt_r <= '0;
        else if (ce)
            cnt_r <= cnt_nxt;
    end

    // Frame lives from select fall to select rise
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            frame_r <= 1'b0;
        else if (ce) begin
            if (cs_fall)
                frame_r <= 1'b1;
            else if (cs_rise)
                frame_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output words and serial shifting

    logic [15:0] word_a, word_b, cur_a, cur_b;
    logic [3:0] bit_idx;

    // Leading zero, range, channel, converter, then result MSB first
    always_comb begin
        word_a = '0;
        word_a[`DASR_BIT_ZERO] = 1'b0;
        word_a[`DASR_BIT_RANGE] = range_r;
        word_a[`DASR_BIT_CHAN] = chan_r;
        word_a[`DASR_BIT_CONV] = 1'b0;
        word_a[`DASR_RES_W-1:0] = res_a_r;
        word_b = word_a;
        word_b[`DASR_BIT_CONV] = 1'b1;
        word_b[`DASR_RES_W-1:0] = res_b_r;
    end

    // Second word of a chained read comes from the other converter
    assign cur_a = cnt_nxt[4] ? word_b : word_a;
    assign cur_b = cnt_nxt[4] ? word_a : word_b;
    // Bit shown after n falls is bit 15 - n, so bit 0 after the 15th
    assign bit_idx = ~cnt_nxt[3:0];

    // Select rise wins over a coincident serial clock edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_out_a <= 1'b0;
            serial_out_b <= 1'b0;
            serial_out_a_oe <= 1'b0;
            serial_out_b_oe <= 1'b0;
        end else if (ce) begin
            if (cs_rise) begin
                serial_out_a_oe <= 1'b0;
                serial_out_b_oe <= 1'b0;
            end else if (cs_fall) begin
                serial_out_a <= 1'b0;
                serial_out_b <= 1'b0;
                serial_out_a_oe <= 1'b1;
                serial_out_b_oe <= 1'b1;
            end else if (sck_fall && frame_r) begin
                if (cnt_nxt >= `DASR_CNT_END) begin
                    serial_out_a_oe <= 1'b0;
                    serial_out_b_oe <= 1'b0;
                end else begin
                    serial_out_a <= cur_a[bit_idx];
                    serial_out_b <= cur_b[bit_idx];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Track and hold

    // Hold from the sampling edge until the rise after the 13th fall
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            hold <= 1'b0;
        else if (ce) begin
            if (cs_fall)
                hold <= 1'b1;
            else if (cs_rise)
                hold <= 1'b0;
            else if (sck_rise && cnt_r >= `DASR_CNT_TRACK)
                hold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power mode machine

    dasr_mode_e mode_r, mode_nxt;
    logic [`DASR_TMR_W-1:0] tmr_r;
    logic tmr_done;

    assign tmr_done = tmr_r == `DASR_TMR_W'(`DASR_PWRUP_CYC - 1);

    // Power-down entry decided once at select rise; later serial clocks are not needed
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            DASR_NORMAL: begin
                if (cs_rise && cnt_r >= `DASR_CNT_PD_LO &&
                    cnt_r < `DASR_CNT_KEEP)
                    mode_nxt = DASR_PARTIAL;
                // Rise before the second fall is taken as a glitch
            end
            DASR_PARTIAL: begin
                if (cs_rise) begin
                    if (cnt_r >= `DASR_CNT_KEEP)
                        mode_nxt = DASR_NORMAL;
                    else if (cnt_r >= `DASR_CNT_PD_LO)
                        mode_nxt = DASR_FULL;
                    else
                        mode_nxt = DASR_PARTIAL;
                end else if (frame_r && cnt_r >= `DASR_CNT_WORD)
                    mode_nxt = DASR_NORMAL;
            end
            DASR_FULL: begin
                if (cs_rise && cnt_r >= `DASR_CNT_KEEP)
                    mode_nxt = DASR_WAKING;
            end
            DASR_WAKING: begin
                if (tmr_done)
                    mode_nxt = DASR_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            mode_r <= DASR_NORMAL;
        else if (ce)
            mode_r <= mode_nxt;
    end

    // Power-up timer runs only while waking from full power-down
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            tmr_r <= '0;
        else if (ce) begin
            if (mode_r != DASR_WAKING || tmr_done)
                tmr_r <= '0;
            else
                tmr_r <= tmr_r + `DASR_TMR_W'(1);
        end
    end

    // Power enables; a dummy frame starts power-up at select fall
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            analog_power <= 1'b1;
            ref_power <= 1'b1;
        end else if (ce) begin
            analog_power <= mode_nxt == DASR_NORMAL ||
                            mode_nxt == DASR_WAKING ||
                            (~cs_s2_r && ~cs_rise);
            ref_power <= mode_nxt != DASR_FULL ||
                         (~cs_s2_r && ~cs_rise);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame bookkeeping seen by software

    logic frame_valid_r, last_valid_r;
    dasr_cnt_t last_cnt_r;

    // A frame only yields real data if it began fully powered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_valid_r <= 1'b0;
            last_valid_r <= 1'b0;
            last_cnt_r <= '0;
        end else if (ce) begin
            if (cs_fall)
                frame_valid_r <= mode_r == DASR_NORMAL;
            if (cs_rise) begin
                last_cnt_r <= cnt_r;
                last_valid_r <= frame_valid_r &&
                                cnt_r >= `DASR_CNT_WORD;
            end
        end
    end

    // Range and channel go to the cores from flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            range_double <= 1'b0;
            channel_select_flag <= 1'b0;
        end else if (ce) begin
            range_double <= range_r;
            channel_select_flag <= chan_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped offsets

    logic [31:0] rdata_nxt;
    logic hit;

    always_comb begin
        rdata_nxt = '0;
        hit = 1'b1;
        unique case (paddr)
            `DASR_OFS_CTRL: begin
                rdata_nxt[`DASR_CTRL_RANGE] = range_r;
                rdata_nxt[`DASR_CTRL_CHAN] = chan_r;
            end
            `DASR_OFS_STATUS: begin
                rdata_nxt[`DASR_ST_MODE_HI:`DASR_ST_MODE_LO] = mode_r;
                rdata_nxt[`DASR_ST_FRAME] = frame_r;
                rdata_nxt[`DASR_ST_HOLD] = hold;
                rdata_nxt[`DASR_ST_VALID] = last_valid_r;
                rdata_nxt[`DASR_ST_ANALOG] = analog_power;
                rdata_nxt[`DASR_ST_REF] = ref_power;
            end
            `DASR_OFS_LASTCNT:
                rdata_nxt[`DASR_CNT_W-1:0] = last_cnt_r;
            default:
                hit = 1'b0;
        endcase
    end

    // Answer is prepared in the setup cycle and shown in the access one
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite)
                prdata <= rdata_nxt;
        end
    end

endmodule

// File: verification/dasr_ctrl_monitor.sv
// Checker of the serial pins of the readout and power control block.
// Assumes it is bound to dasr_ctrl and sees only its ports.
`timescale 1ns/100ps

module dasr_ctrl_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial pins and hold
    input wire logic conv_start_select_n,
    input wire logic serial_clock,
    input wire logic serial_out_a,
    input wire logic serial_out_a_oe,
    input wire logic serial_out_b,
    input wire logic serial_out_b_oe,
    input wire logic hold
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////
    // Raw pin falls while selected; the design sees them a few clocks
    // later, so the edge checks below leave six clocks of slack, bar chk_shift_fall
    logic [5:0] fcnt_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fcnt_r <= 6'h00;
        end else if (conv_start_select_n) begin
            fcnt_r <= 6'h00;
        end else if ($fell(serial_clock) && fcnt_r != 6'h3f) begin
            fcnt_r <= fcnt_r + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin relations
    chk_fall_drive: assert property ($fell(conv_start_select_n)
        |-> ##6 (serial_out_a_oe && serial_out_b_oe && hold
        && !serial_out_a && !serial_out_b))
        else $error("select fall did not drive zero");
    chk_oe_pair: assert property (serial_out_a_oe == serial_out_b_oe)
        else $error("output enables differ");
    chk_rise_tri: assert property ($rose(conv_start_select_n) |-> ##6
        !(serial_out_a_oe || serial_out_b_oe || hold))
        else $error("select rise left outputs driven");
    chk_idle_tri: assert property (conv_start_select_n [*8] |->
        !(serial_out_a_oe || serial_out_b_oe)) else $error("idle drive");
    chk_shift_fall: assert property ($rose(serial_clock)
        && !conv_start_select_n |-> ##2
        $stable({serial_out_a, serial_out_b}) [*3])
        else $error("data changed in high phase");
    chk_track_early: assert property ($rose(serial_clock)
        && !conv_start_select_n && fcnt_r == 6'h0c |-> ##6 hold)
        else $error("track before thirteenth fall");
    chk_track_late: assert property ($rose(serial_clock)
        && !conv_start_select_n && fcnt_r == 6'h0d |-> ##6 !hold)
        else $error("no track after thirteenth fall");
    chk_second_zero: assert property ($fell(serial_clock)
        && !conv_start_select_n && fcnt_r == 6'h0f |-> ##6
        (serial_out_a_oe && !serial_out_a && !serial_out_b))
        else $error("second word lacks leading zero");
    chk_tri_last: assert property ($fell(serial_clock)
        && !conv_start_select_n && fcnt_r == 6'h1f |-> ##6
        !(serial_out_a_oe || serial_out_b_oe))
        else $error("drive kept after last fall");
endmodule

bind dasr_ctrl dasr_ctrl_monitor mon_u (.clock, .rst,
    .conv_start_select_n, .serial_clock, .serial_out_a, .serial_out_a_oe,
    .serial_out_b, .serial_out_b_oe, .hold);

// File: verification/dasr_host.sv
// Host serial port model: drives select and serial clock, shifts in
// both data lines. Assumes the bench's block clock.
`timescale 1ns/100ps

module dasr_host (
    // Bench clock
    input wire logic clock,
    // Serial pins
    output logic sel_n,
    output logic sclk,
    input wire logic da,
    input wire logic da_oe,
    input wire logic db,
    input wire logic db_oe
);
    logic [31:0] cap_a;
    logic [31:0] cap_b;
    logic oe_held;
    logic oe_after;

    // Pins idle high; the serial clock stands still between frames
    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        cap_a = 32'h0;
        cap_b = 32'h0;
    end

    // One frame of nf falls at 48 ns; a released line reads inverted
    // so that a stale bit can never pass for a driven one
    task automatic frame(input int nf);
        sel_n <= 1'b0;
        repeat (12) @(posedge clock);
        for (int k = 0; k < nf; k++) begin
            // Taken at the end of the high phase: the bit that a slow
            // host reading on the rising edge would see
            cap_a = {cap_a[30:0], da_oe ? da : ~cap_a[0]};
            cap_b = {cap_b[30:0], db_oe ? db : ~cap_b[0]};
            sclk <= 1'b0;
            repeat (6) @(posedge clock);
            sclk <= 1'b1;
            repeat (6) @(posedge clock);
        end
        repeat (12) @(posedge clock);
        oe_held = da_oe | db_oe;
        sel_n <= 1'b1;
        repeat (24) @(posedge clock);
        oe_after = da_oe | db_oe;
    endtask
endmodule

// File: verification/dasr_ctrl_tb.sv
// Bench of the readout and power control block: APB master, host
// model on the serial pins, rows of frames, then hand-written cases.
`timescale 1ns/100ps
`include "dasr_params.svh"

module dasr_ctrl_tb
    import dasr_pkg::*;
;
    typedef struct {
        int nf;
        logic [1:0] ctrl;
        dasr_mode_e mode;
    } dasr_row_s;

    // Falls per frame, control value, mode expected afterwards
    dasr_row_s rows [12] = '{'{1, 2'h0, DASR_NORMAL},
        '{32, 2'h1, DASR_NORMAL}, '{16, 2'h2, DASR_NORMAL},
        '{12, 2'h3, DASR_NORMAL}, '{10, 2'h0, DASR_NORMAL},
        '{2, 2'h1, DASR_PARTIAL}, '{1, 2'h2, DASR_PARTIAL},
        '{16, 2'h3, DASR_NORMAL}, '{9, 2'h0, DASR_PARTIAL},
        '{9, 2'h1, DASR_FULL}, '{1, 2'h2, DASR_FULL},
        '{12, 2'h3, DASR_WAKING}};

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er;
    logic sel_n, sclk, out_a, oe_a, out_b, oe_b;
    logic hold, chan, rng, apw, rpw;
    logic [11:0] res_a = 12'h000;
    logic [11:0] res_b = 12'h000;
    logic [15:0] wa, wb;
    logic [1:0] exp2;
    dasr_row_s r;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////
    dasr_ctrl dut_u (.clock(clock), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start_select_n(sel_n),
        .serial_clock(sclk), .serial_out_a(out_a),
        .serial_out_a_oe(oe_a), .serial_out_b(out_b),
        .serial_out_b_oe(oe_b), .conv_result_a(res_a),
        .conv_result_b(res_b), .hold(hold), .channel_select_flag(chan),
        .range_double(rng), .analog_power(apw), .ref_power(rpw));

    dasr_host host_u (.clock(clock), .sel_n(sel_n), .sclk(sclk),
        .da(out_a), .da_oe(oe_a), .db(out_b), .db_oe(oe_b));

    // 250 MHz block clock
    always #2 clock = ~clock;

    // Hang guard: the whole run needs about 2400 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One APB transfer; waits for pready, then one idle edge so the
    // next setup never lands in the same time step as the release;
    // only the hang guard ends a wait that never sees pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Rows of frames, then waking, unmapped access and reset
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            res_a <= 12'h5a3 + 12'(i * 97);
            res_b <= 12'hc3e - 12'(i * 41);
            apb(1'b1, `DASR_OFS_CTRL, {30'h0, r.ctrl});
            // Range and channel pins follow the register one clock later
            @(posedge clock);
            chk({rng, chan}, {r.ctrl[0], r.ctrl[1]});
            host_u.frame(r.nf);
            wa = {1'b0, r.ctrl[0], r.ctrl[1], 1'b0, res_a};
            wb = {1'b0, r.ctrl[0], r.ctrl[1], 1'b1, res_b};
            exp2 = {r.nf != 32, 1'b0};
            chk({host_u.oe_held, host_u.oe_after}, exp2);
            if (i == 1) chk(host_u.cap_a, {wa, wb});
            if (i == 1) chk(host_u.cap_b, {wb, wa});
            if (i == 2) chk(host_u.cap_a[15:0], wa);
            if (i == 2) chk(host_u.cap_b[15:0], wb);
            apb(1'b0, `DASR_OFS_STATUS, 32'h0);
            chk(rd[1:0], r.mode);
            // Reference stays up unless fully down; analog only when
            // normal or waking, with the select idle high
            exp2 = {r.mode != DASR_FULL,
                    r.mode == DASR_NORMAL || r.mode == DASR_WAKING};
            chk({rpw, apw}, exp2);
            apb(1'b0, `DASR_OFS_LASTCNT, 32'h0);
            chk(rd[5:0], r.nf[5:0]);
            $display("row %0d done", i);
        end
        // Waking returns to normal once the power-up time has passed
        repeat (260) @(posedge clock);
        apb(1'b0, `DASR_OFS_STATUS, 32'h0);
        chk(rd[1:0], DASR_NORMAL);
        $display("wake test done");
        // Unmapped place: error answer, write ignored, reads zero
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        apb(1'b0, 8'h0c, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        $display("unmapped test done");
        // Reset in mid-run restores power and clears control
        apb(1'b1, `DASR_OFS_CTRL, 32'h3);
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk({apw, rpw, hold, oe_a, rng, chan}, 6'h30);
        apb(1'b0, `DASR_OFS_STATUS, 32'h0);
        chk(rd[6:0], 7'h60);
        apb(1'b0, `DASR_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        wrap_up();
    end
endmodule
